// file: src/ieig_axis_cmp.sv
// axis comparator: unsigned magnitude against a 7-bit threshold
`timescale 1ns/1ps
`default_nettype none
module ieig_axis_cmp (
  input  wire logic [7:0] sample,
  input  wire logic [6:0] threshold,
  output logic            above,
  output logic            below
);
  logic [6:0] mag;
  // ----------------------------------------------------------------
  // magnitude of two's-complement sample, saturated to 7 bits
  // ----------------------------------------------------------------
  always_comb begin
    if (sample[7]) begin
      mag = (sample == 8'h80) ? 7'h7f : 7'((~sample) + 8'h01);
    end else begin
      mag = sample[6:0];
    end
    above = (mag >= threshold);
    below = (mag < threshold);
  end
endmodule : ieig_axis_cmp
`default_nettype wire

// file: src/ieig_event_gen.sv
// inertial event source one: config, threshold, source register, duration filter
// Behaviour
// - reading the dummy filter-rezero address pulses the filter rezero output.
// - the combine select bit picks OR of enabled events when clear and AND when set.
// - with latching on, the request is held after the event until the source is read.
// - an enabled above event fires when the axis magnitude reaches the threshold.
// - an enabled below event fires when the axis magnitude is under the threshold.
// - the threshold is 7-bit unsigned and above means magnitude at or over it.
// - below means magnitude strictly less than the threshold.
// - the active flag follows the combined condition once it passes the duration filter and drives the interrupt output.
// - the source register shows six axis flags and the active flag, live or latched.
// - reading the source register clears it and the interrupt and allows a refresh.
// - counter mode 0 resets the duration counter on inactivity, mode 1 decrements it.
// - after reset the threshold and counter mode are zero.
// - after reset all enables, combine select and latch bits are zero.
// - the duration counter holds while latching is on and the event has occurred.
// - the duration counts in whole output samples, one step per sample.
`timescale 1ns/1ps
`default_nettype none
module ieig_event_gen (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       sample_valid,
  input  wire logic [7:0] x_sample,
  input  wire logic [7:0] y_sample,
  input  wire logic [7:0] z_sample,
  input  wire logic [7:0] min_duration,
  output logic            inertial_irq_one,
  output logic            filter_rezero
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] cfg_reg,   cfg_next;
  logic [7:0] ths_reg,   ths_next;
  logic [7:0] src_reg,   src_next;
  logic [7:0] dur_reg,   dur_next;
  logic [7:0] rdata_reg, rdata_next;
  logic       irq_reg,   irq_next;
  logic       rez_reg,   rez_next;
  logic [2:0] above_v, below_v;
  logic [5:0] ev_flags, en_mask;
  logic       any_en, combined, qualified, rd_src, hold;

  function automatic logic [5:0] enabled_mask(input logic [7:0] cfg);
    enabled_mask = cfg[ieig_pkg::CFG_Z_ABOVE:ieig_pkg::CFG_X_BELOW];
  endfunction : enabled_mask

  localparam logic [7:0] DUR_INC = ieig_pkg::DUR_ONE;
  localparam logic [7:0] DUR_MAX = 8'hff;

  function automatic logic [8:0] dur_plus_one(input logic [7:0] d);
    dur_plus_one = {1'b0, d} + {1'b0, DUR_INC};
  endfunction : dur_plus_one

  // ----------------------------------------------------------------
  // per-axis comparators
  // ----------------------------------------------------------------
  ieig_axis_cmp u_cmp_x (.sample(x_sample), .threshold(ths_reg[ieig_pkg::THS_MSB:0]),
                         .above(above_v[0]), .below(below_v[0]));
  ieig_axis_cmp u_cmp_y (.sample(y_sample), .threshold(ths_reg[ieig_pkg::THS_MSB:0]),
                         .above(above_v[1]), .below(below_v[1]));
  ieig_axis_cmp u_cmp_z (.sample(z_sample), .threshold(ths_reg[ieig_pkg::THS_MSB:0]),
                         .above(above_v[2]), .below(below_v[2]));

  // ----------------------------------------------------------------
  // event combination
  // ----------------------------------------------------------------
  always_comb begin
    en_mask  = enabled_mask(cfg_reg);
    ev_flags = {above_v[2], below_v[2], above_v[1], below_v[1], above_v[0], below_v[0]}
               & en_mask;
    any_en   = |en_mask;
    if (cfg_reg[ieig_pkg::CFG_AND_SEL]) begin
      combined = any_en && (ev_flags == en_mask);
    end else begin
      combined = |ev_flags;
    end
    qualified = combined && (dur_plus_one(dur_reg) > {1'b0, min_duration});
  end

  // ----------------------------------------------------------------
  // access decode shared by counter and source
  // ----------------------------------------------------------------
  always_comb begin
    rd_src = reg_rd && (reg_addr == ieig_pkg::ADDR_SOURCE);
    hold   = cfg_reg[ieig_pkg::CFG_LATCH] && src_reg[ieig_pkg::SRC_ACTIVE]
             && !rd_src;
  end

  // ----------------------------------------------------------------
  // configuration and threshold registers
  // ----------------------------------------------------------------
  always_comb begin
    cfg_next = cfg_reg;
    ths_next = ths_reg;
    if (reg_wr) begin
      case (reg_addr)
        ieig_pkg::ADDR_CONFIG:    cfg_next = reg_wdata;
        ieig_pkg::ADDR_THRESHOLD: ths_next = reg_wdata;
        default:                  cfg_next = cfg_reg;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg <= ieig_pkg::CFG_RESET;
      ths_reg <= ieig_pkg::THS_RESET;
    end else begin
      cfg_reg <= cfg_next;
      ths_reg <= ths_next;
    end
  end

  // ----------------------------------------------------------------
  // read data and filter rezero pulse
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = rdata_reg;
    rez_next   = 1'b0;
    if (reg_rd) begin
      case (reg_addr)
        ieig_pkg::ADDR_CONFIG:        rdata_next = cfg_reg;
        ieig_pkg::ADDR_THRESHOLD:     rdata_next = ths_reg;
        ieig_pkg::ADDR_SOURCE:        rdata_next = src_reg;
        ieig_pkg::ADDR_FILTER_REZERO: begin
          rdata_next = ieig_pkg::RD_ZERO;
          rez_next   = 1'b1;
        end
        default:                      rdata_next = ieig_pkg::RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= ieig_pkg::RD_ZERO;
      rez_reg   <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rez_reg   <= rez_next;
    end
  end

  // ----------------------------------------------------------------
  // duration counter
  // ----------------------------------------------------------------
  always_comb begin
    dur_next = dur_reg;
    if (sample_valid && !hold) begin
      if (combined) begin
        if (dur_reg != DUR_MAX) begin
          dur_next = 8'(dur_plus_one(dur_reg));
        end
      end else if (ths_reg[ieig_pkg::THS_COUNTER_DECREMENT_MODE]) begin
        if (dur_reg != ieig_pkg::DUR_ZERO) begin
          dur_next = 8'(dur_reg - DUR_INC);
        end
      end else begin
        dur_next = ieig_pkg::DUR_ZERO;
      end
    end
    if (cfg_reg[ieig_pkg::CFG_LATCH] && rd_src) begin
      dur_next = ieig_pkg::DUR_ZERO;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dur_reg <= ieig_pkg::DUR_ZERO;
    end else begin
      dur_reg <= dur_next;
    end
  end

  // ----------------------------------------------------------------
  // source register and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    src_next = src_reg;
    if (cfg_reg[ieig_pkg::CFG_LATCH]) begin
      if (rd_src) begin
        src_next = ieig_pkg::SRC_RESET;
      end
      if (sample_valid && !hold && qualified) begin
        src_next = {1'b0, 1'b1, ev_flags};
      end
    end else begin
      if (sample_valid) begin
        src_next = {1'b0, qualified, ev_flags};
      end else if (rd_src) begin
        src_next = ieig_pkg::SRC_RESET;
      end
    end
    irq_next = src_next[ieig_pkg::SRC_ACTIVE];
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      src_reg <= ieig_pkg::SRC_RESET;
      irq_reg <= 1'b0;
    end else begin
      src_reg <= src_next;
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata        = rdata_reg;
  assign inertial_irq_one = irq_reg;
  assign filter_rezero    = rez_reg;
endmodule : ieig_event_gen
`default_nettype wire

// file: src/ieig_pkg.sv
// package: register map, field positions and reset values of the inertial event source
`default_nettype none
package ieig_pkg;
  // ----------------------------------------------------------------
  // register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FILTER_REZERO = 8'h23;
  localparam logic [7:0] ADDR_CONFIG        = 8'h30;
  localparam logic [7:0] ADDR_SOURCE        = 8'h31;
  localparam logic [7:0] ADDR_THRESHOLD     = 8'h32;
  // ----------------------------------------------------------------
  // config fields
  // ----------------------------------------------------------------
  localparam int CFG_X_BELOW   = 0;
  localparam int CFG_X_ABOVE   = 1;
  localparam int CFG_Y_BELOW   = 2;
  localparam int CFG_Y_ABOVE   = 3;
  localparam int CFG_Z_BELOW   = 4;
  localparam int CFG_Z_ABOVE   = 5;
  localparam int CFG_LATCH     = 6;
  localparam int CFG_AND_SEL   = 7;
  // ----------------------------------------------------------------
  // threshold and source fields and resets
  // ----------------------------------------------------------------
  localparam int THS_COUNTER_DECREMENT_MODE      = 7;
  localparam int THS_MSB       = 6;
  localparam int SRC_ACTIVE    = 6;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] THS_RESET = 8'h00;
  localparam logic [7:0] SRC_RESET = 8'h00;
  localparam logic [7:0] DUR_ZERO  = 8'h00;
  localparam logic [7:0] DUR_ONE   = 8'h01;
  localparam logic [7:0] RD_ZERO   = 8'h00;
  // sample periods per step (informational timing)
  localparam real STEP_400HZ_MS = 2.5;
  localparam real STEP_100HZ_MS = 10.0;
  localparam real CLK_PERIOD_NS = 10.0;
  localparam int  STEP_400HZ_CYC = int'(STEP_400HZ_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int  STEP_100HZ_CYC = int'(STEP_100HZ_MS * 1.0e6 / CLK_PERIOD_NS);
endpackage : ieig_pkg
`default_nettype wire

// file: verif/ieig_event_gen_asserts.sv
// checker: port-level properties of the inertial event source
`timescale 1ns/1ps
`default_nettype none
module ieig_event_gen_chk (
  input wire logic       mclk,
  input wire logic       rstn,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       sample_valid,
  input wire logic       inertial_irq_one,
  input wire logic       filter_rezero
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_src_rd; reg_rd && reg_addr == 8'h31 && !sample_valid; endsequence
  sequence s_wr_rw; reg_wr && (reg_addr == 8'h30 || reg_addr == 8'h32); endsequence
  property p_rz; filter_rezero == $past(reg_rd && reg_addr == 8'h23); endproperty
  a_rz: assert property (p_rz) else $error("rezero pulse wrong");
  property p_clr; s_src_rd |=> !inertial_irq_one; endproperty
  a_clr: assert property (p_clr) else $error("irq not cleared");
  property p_two; s_src_rd ##1 !sample_valid ##1 s_src_rd |=> reg_rdata == 8'h00; endproperty
  a_two: assert property (p_two) else $error("source not cleared");
  property p_ia; reg_rd && reg_addr == 8'h31 |=> reg_rdata[6] == $past(inertial_irq_one);
  endproperty
  a_ia: assert property (p_ia) else $error("irq differs from active");
  property p_hold; !sample_valid && !(reg_rd && reg_addr == 8'h31)
    |=> $stable(inertial_irq_one); endproperty
  a_hold: assert property (p_hold) else $error("irq moved between samples");
  property p_rise; $rose(inertial_irq_one) |-> $past(sample_valid); endproperty
  a_rise: assert property (p_rise) else $error("irq rose without sample");
  property p_fall; $fell(inertial_irq_one)
    |-> $past(sample_valid || (reg_rd && reg_addr == 8'h31)); endproperty
  a_fall: assert property (p_fall) else $error("irq fell without cause");
  property p_rw; s_wr_rw ##2 reg_rd && reg_addr == $past(reg_addr, 2)
    |=> reg_rdata == $past(reg_wdata, 3); endproperty
  a_rw: assert property (p_rw) else $error("register readback wrong");
endmodule : ieig_event_gen_chk
bind ieig_event_gen ieig_event_gen_chk u_ieig_event_gen_chk (.mclk(mclk), .rstn(rstn),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .sample_valid(sample_valid),
  .inertial_irq_one(inertial_irq_one), .filter_rezero(filter_rezero));
`default_nettype wire

// file: verif/ieig_host_model.sv
// host model: register access master for the inertial event source
`timescale 1ns/1ps
`default_nettype none
module ieig_host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_wr = 1'b0,
  output logic            reg_rd = 1'b0,
  output logic      [7:0] reg_addr = 8'h00,
  output logic      [7:0] reg_wdata = 8'h00
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  // one read strobe per access, a read of the source address clears the source
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask : rd
endmodule : ieig_host_model
`default_nettype wire

// file: verif/inertial_event_interrupt_gen_tb_top.sv
// testbench: random and corner checks of the inertial event source
`timescale 1ns/1ps
`default_nettype none
module inertial_event_interrupt_gen_tb_top;
  logic mclk = 1'b0, rstn = 1'b0, reg_wr, reg_rd, sample_valid = 1'b0;
  logic inertial_irq_one, filter_rezero;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, got, cfg, xv, yv, zv;
  logic [7:0] x_sample = 8'h00, y_sample = 8'h00, z_sample = 8'h00, min_duration = 8'h00;
  logic [6:0] ths;
  logic [7:0] exp_v;
  logic [7:0] cx [5] = '{8'h40, 8'h3f, 8'hc0, 8'h80, 8'h01};
  logic [7:0] ra [3] = '{8'h30, 8'h32, 8'h40};
  bit         pat [8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  int n_fail = 0, tests_run = 0;
  always #5 mclk = ~mclk;
  ieig_host_model u_ieig_host_model (.mclk(mclk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  ieig_event_gen u_ieig_event_gen (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .x_sample(x_sample), .y_sample(y_sample),
    .z_sample(z_sample), .min_duration(min_duration),
    .inertial_irq_one(inertial_irq_one), .filter_rezero(filter_rezero));
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  function automatic logic [6:0] mag(input logic [7:0] s);
    return s[7] ? ((s == 8'h80) ? 7'h7f : 7'(-s)) : s[6:0];
  endfunction : mag
  function automatic logic [7:0] exp_src(input logic [7:0] c, input logic [6:0] t,
                                         input logic [7:0] x, y, z);
    logic [5:0] f;
    f = {mag(z) >= t, mag(z) < t, mag(y) >= t, mag(y) < t, mag(x) >= t, mag(x) < t} & c[5:0];
    return {1'b0, c[7] ? (f == c[5:0] && f != 6'h00) : |f, f};
  endfunction : exp_src
  task automatic smp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
    @(posedge mclk);
    sample_valid <= 1'b1;
    x_sample     <= x;
    y_sample     <= y;
    z_sample     <= z;
    @(posedge mclk);
    sample_valid <= 1'b0;
    #1;
  endtask : smp
  initial begin
    #200us;
    n_fail++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'h06b6));
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    foreach (ra[i]) begin
      u_ieig_host_model.rd(ra[i], got);
      check(got, 8'h00);
    end
    u_ieig_host_model.rd(8'h23, got);
    check({7'h00, filter_rezero}, 8'h01);
    for (int i = 0; i < 60; i++) begin
      cfg = (i < 5) ? (i[0] ? 8'h95 : 8'h2a) : (8'($urandom) & 8'hbf);
      ths = (i < 5) ? 7'h40 : 7'($urandom);
      xv = (i < 5) ? cx[i] : 8'($urandom);
      yv = (i < 5) ? 8'hfe : 8'($urandom);
      zv = (i < 5) ? 8'h02 : 8'($urandom);
      exp_v = exp_src(cfg, ths, xv, yv, zv);
      u_ieig_host_model.wr(8'h30, cfg);
      u_ieig_host_model.rd(8'h30, got);
      check(got, cfg);
      u_ieig_host_model.wr(8'h32, {1'b0, ths});
      u_ieig_host_model.rd(8'h32, got);
      check(got, {1'b0, ths});
      smp(xv, yv, zv);
      check({7'h00, inertial_irq_one}, {7'h00, exp_v[6]});
      u_ieig_host_model.rd(8'h31, got);
      check(got & {2'b01, cfg[5:0]}, exp_v);
    end
    u_ieig_host_model.wr(8'h30, 8'h02);
    min_duration <= 8'h02;
    for (int m = 0; m < 2; m++) begin
      u_ieig_host_model.wr(8'h32, {m[0], 7'h10});
      foreach (pat[k]) smp(pat[k] ? 8'h20 : 8'h00, 8'h00, 8'h00);
      check({7'h00, inertial_irq_one}, {7'h00, m[0]});
    end
    @(posedge mclk);
    min_duration <= 8'h00;
    u_ieig_host_model.wr(8'h30, 8'h42);
    u_ieig_host_model.rd(8'h31, got);
    check(got, 8'h42);
    smp(8'h30, 8'h00, 8'h00);
    smp(8'h00, 8'h00, 8'h00);
    check({7'h00, inertial_irq_one}, 8'h01);
    u_ieig_host_model.rd(8'h31, got);
    check(got & 8'h42, 8'h42);
    u_ieig_host_model.rd(8'h31, got);
    check({got[7:1], inertial_irq_one}, 8'h00);
    end_of_test();
  end
endmodule : inertial_event_interrupt_gen_tb_top
`default_nettype wire
